// file: src/cdt_defines.vh
`ifndef CDT_DEFINES_VH
`define CDT_DEFINES_VH

// Register indices; byte offset is four times the index
`define CDT_IDX_ADDR    4'd0
`define CDT_IDX_AMASK   4'd1
`define CDT_IDX_DATA    4'd2
`define CDT_IDX_DMASK   4'd3
`define CDT_IDX_PC0     4'd4
`define CDT_IDX_PCMASK  4'd8
`define CDT_IDX_CTRL    4'd9
`define CDT_IDX_STAT    4'd10
`define CDT_IDX_IMASK   4'd11
`define CDT_IDX_LAST    4'd11
`define CDT_NUM_BKPT    9

// Byte offsets on the register bus
`define CDT_OFF_ADDR    12'h000
`define CDT_OFF_PCMASK  12'h020
`define CDT_OFF_CTRL    12'h024
`define CDT_OFF_STAT    12'h028
`define CDT_OFF_IMASK   12'h02c

// Control register fields
`define CDT_CTRL_EN       0
`define CDT_CTRL_TWO_LVL  1
`define CDT_CTRL_L1_LSB   2
`define CDT_CTRL_L2_LSB   5
`define CDT_CTRL_RESP_IRQ 8
`define CDT_CTRL_EMU      9
`define CDT_CTRL_CRIT_LSB 10
`define CDT_CTRL_WIDTH    13

// Status / mask fields
`define CDT_ST_L1_HIT   0
`define CDT_ST_FIRED    1
`define CDT_ST_SER_DONE 2
`define CDT_ST_WIDTH    3

// Reset values
`define CDT_RST_BKPT    32'h0000_0000
`define CDT_RST_CTRL    13'h0000
`define CDT_RST_STAT    3'h0
`define CDT_RST_IMASK   3'h0

// Serial frame: 8-bit command then 32-bit data, MSB first
`define CDT_SER_FRAME   6'd40
`define CDT_SER_WR_BIT  39

// Trace status code for the halted state
`define CDT_PST_HALTED  4'hf

`endif

// file: src/cdt_match.v
// Masked equality: bits set in the mask take no part in the compare
module cdt_match #(
  parameter W = 32
) (
  input  wire [W-1:0] value,
  input  wire [W-1:0] ref_value,
  input  wire [W-1:0] mask,
  output wire         hit
);

  assign hit = ~|((value ^ ref_value) & ~mask);

endmodule

// file: src/cdt_top.v
`include "cdt_defines.vh"

module cdt_top #(
  parameter TRACE_EN = 1
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  input  wire [2:0]  pprot,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        debug_serial_in,
  input  wire        debug_serial_clock,
  output reg         debug_serial_out,
  input  wire        cpu_addr_valid,
  input  wire [31:0] cpu_addr,
  input  wire        cpu_data_valid,
  input  wire [31:0] cpu_data,
  input  wire        cpu_pc_valid,
  input  wire [31:0] cpu_pc,
  input  wire [3:0]  cpu_status,
  input  wire [3:0]  cpu_ddata,
  input  wire        cpu_halted,
  input  wire        cpu_debug_isr,
  input  wire [2:0]  cpu_irq_level,
  output reg         cpu_halt_req,
  output reg         debug_irq,
  output reg  [2:0]  irq_level_fwd,
  output reg  [3:0]  processor_status_bus,
  output reg  [3:0]  trace_data_bus,
  output reg         trace_clock_out,
  output reg         halt_indicator,
  output reg         irq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_LVL1  = 2'd1;
  localparam ST_LVL2  = 2'd2;
  localparam ST_FIRED = 2'd3;

  reg [31:0]                bkpt_q [0:`CDT_NUM_BKPT-1];
  reg [`CDT_CTRL_WIDTH-1:0] ctrl_q;
  reg [`CDT_ST_WIDTH-1:0]   stat_q;
  reg [`CDT_ST_WIDTH-1:0]   imask_q;
  reg [1:0]                 state_q;
  reg [1:0]                 state_d;

  // Serial channel synchronisers and shifters
  reg        sclk_s1_q;
  reg        sclk_s2_q;
  reg        sclk_s3_q;
  reg        sin_s1_q;
  reg        sin_s2_q;
  reg [39:0] sin_shift_q;
  reg [31:0] sout_shift_q;
  reg [5:0]  sbit_cnt_q;

  wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire [39:0] sin_next = {sin_shift_q[38:0], sin_s2_q};
  wire ser_exec = ce & sclk_rise & (sbit_cnt_q == `CDT_SER_FRAME - 6'd1);
  wire ser_wr = ser_exec & sin_next[`CDT_SER_WR_BIT];
  wire [3:0] ser_idx = sin_next[35:32];

  // Register bus decode
  wire [3:0] ap_idx = paddr[5:2];
  wire ap_mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) &&
                   (paddr <= `CDT_OFF_IMASK);
  wire ap_priv_ok = pprot[0] | (paddr > `CDT_OFF_PCMASK);
  wire ap_done = ce & psel & penable & pready;
  wire ap_wr = ap_done & pwrite & ap_mapped & ap_priv_ok;
  wire [31:0] ap_bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  function [31:0] rd_mux;
    input [3:0] idx;
    begin
      rd_mux = 32'h0000_0000;
      if (idx < `CDT_IDX_CTRL) begin
        rd_mux = bkpt_q[idx];
      end else if (idx == `CDT_IDX_CTRL) begin
        rd_mux = {{(32-`CDT_CTRL_WIDTH){1'b0}}, ctrl_q};
      end else if (idx == `CDT_IDX_STAT) begin
        rd_mux = {{(32-`CDT_ST_WIDTH){1'b0}}, stat_q};
      end else if (idx == `CDT_IDX_IMASK) begin
        rd_mux = {{(32-`CDT_ST_WIDTH){1'b0}}, imask_q};
      end
    end
  endfunction

  // Comparators
  wire       addr_hit_raw;
  wire       data_hit_raw;
  wire [3:0] pc_hit_raw;

  cdt_match #(.W(32)) u_addr_match (
    .value     (cpu_addr),
    .ref_value (bkpt_q[`CDT_IDX_ADDR]),
    .mask      (bkpt_q[`CDT_IDX_AMASK]),
    .hit       (addr_hit_raw)
  );

  cdt_match #(.W(32)) u_data_match (
    .value     (cpu_data),
    .ref_value (bkpt_q[`CDT_IDX_DATA]),
    .mask      (bkpt_q[`CDT_IDX_DMASK]),
    .hit       (data_hit_raw)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pc
      cdt_match #(.W(32)) u_pc_match (
        .value     (cpu_pc),
        .ref_value (bkpt_q[`CDT_IDX_PC0 + gi]),
        .mask      (bkpt_q[`CDT_IDX_PCMASK]),
        .hit       (pc_hit_raw[gi])
      );
    end
  endgenerate

  wire [2:0] hits = {cpu_pc_valid & |pc_hit_raw,
                     cpu_data_valid & data_hit_raw,
                     cpu_addr_valid & addr_hit_raw};
  wire [2:0] l1_en = ctrl_q[`CDT_CTRL_L1_LSB +: 3];
  wire [2:0] l2_en = ctrl_q[`CDT_CTRL_L2_LSB +: 3];
  // Every enabled condition must hit together; an empty selection never fires
  wire l1_cond = (|l1_en) & ((hits & l1_en) == l1_en);
  wire l2_cond = (|l2_en) & ((hits & l2_en) == l2_en);
  wire ctrl_wr = (ser_wr & (ser_idx == `CDT_IDX_CTRL)) |
                 (ap_wr & (ap_idx == `CDT_IDX_CTRL));

  reg fire;
  reg l1_set;
  always @* begin
    state_d = state_q;
    fire = 1'b0;
    l1_set = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (ctrl_q[`CDT_CTRL_EN]) begin
          state_d = ST_LVL1;
        end
      end
      ST_LVL1: begin
        if (!ctrl_q[`CDT_CTRL_EN]) begin
          state_d = ST_IDLE;
        end else if (l1_cond) begin
          l1_set = 1'b1;
          if (ctrl_q[`CDT_CTRL_TWO_LVL]) begin
            state_d = ST_LVL2;
          end else begin
            fire = 1'b1;
            state_d = ST_FIRED;
          end
        end
      end
      ST_LVL2: begin
        if (!ctrl_q[`CDT_CTRL_EN]) begin
          state_d = ST_IDLE;
        end else if (l2_cond) begin
          fire = 1'b1;
          state_d = ST_FIRED;
        end
      end
      default: begin
        state_d = ST_FIRED;
      end
    endcase
    // Rewriting control re-arms the trigger from scratch
    if (ctrl_wr) begin
      state_d = ST_IDLE;
      fire = 1'b0;
      l1_set = 1'b0;
    end
  end

  wire [`CDT_ST_WIDTH-1:0] st_set = {ser_exec, fire, l1_set};
  wire [`CDT_ST_WIDTH-1:0] st_clr =
      ((ser_wr & (ser_idx == `CDT_IDX_STAT)) ? sin_next[`CDT_ST_WIDTH-1:0] : 3'h0) |
      ((ap_wr & (ap_idx == `CDT_IDX_STAT)) ? (pwdata[2:0] & ap_bmask[2:0]) : 3'h0);
  wire [`CDT_ST_WIDTH-1:0] stat_d = (stat_q & ~st_clr) | st_set;

  wire [3:0] pst_d = cpu_halted ? `CDT_PST_HALTED : cpu_status;
  wire [2:0] crit_lvl = ctrl_q[`CDT_CTRL_CRIT_LSB +: 3];

  integer i;
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < `CDT_NUM_BKPT; i = i + 1) begin
        bkpt_q[i] <= `CDT_RST_BKPT;
      end
      ctrl_q <= `CDT_RST_CTRL;
      stat_q <= `CDT_RST_STAT;
      imask_q <= `CDT_RST_IMASK;
      state_q <= ST_IDLE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
      sin_shift_q <= 40'h00_0000_0000;
      sout_shift_q <= 32'h0000_0000;
      sbit_cnt_q <= 6'd0;
      debug_serial_out <= 1'b0;
      cpu_halt_req <= 1'b0;
      debug_irq <= 1'b0;
      irq_level_fwd <= 3'h0;
      processor_status_bus <= 4'h0;
      trace_data_bus <= 4'h0;
      trace_clock_out <= 1'b0;
      halt_indicator <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      // Serial debug channel, sampled on the core clock
      sclk_s1_q <= debug_serial_clock;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sin_s1_q <= debug_serial_in;
      sin_s2_q <= sin_s1_q;
      if (sclk_rise) begin
        sin_shift_q <= sin_next;
        sbit_cnt_q <= ser_exec ? 6'd0 : sbit_cnt_q + 6'd1;
      end
      if (ser_exec && !ser_wr) begin
        sout_shift_q <= (ser_idx <= `CDT_IDX_LAST) ? rd_mux(ser_idx) : 32'h0000_0000;
      end else if (sclk_fall) begin
        debug_serial_out <= sout_shift_q[31];
        sout_shift_q <= {sout_shift_q[30:0], 1'b0};
      end

      // Register bus: one wait state so read data leaves a flop
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= ~ap_mapped | ~ap_priv_ok;
        prdata <= (ap_mapped && ap_priv_ok && !pwrite) ? rd_mux(ap_idx) : 32'h0000_0000;
      end

      // Serial writes win a same-cycle collision on a breakpoint, control or irq mask register; status clears from both buses apply
      for (i = 0; i < `CDT_NUM_BKPT; i = i + 1) begin
        if (ser_wr && ser_idx == i[3:0]) begin
          bkpt_q[i] <= sin_next[31:0];
        end else if (ap_wr && ap_idx == i[3:0]) begin
          bkpt_q[i] <= (bkpt_q[i] & ~ap_bmask) | (pwdata & ap_bmask);
        end
      end
      if (ser_wr && ser_idx == `CDT_IDX_CTRL) begin
        ctrl_q <= sin_next[`CDT_CTRL_WIDTH-1:0];
      end else if (ap_wr && ap_idx == `CDT_IDX_CTRL) begin
        ctrl_q <= (ctrl_q & ~ap_bmask[`CDT_CTRL_WIDTH-1:0]) |
                  (pwdata[`CDT_CTRL_WIDTH-1:0] & ap_bmask[`CDT_CTRL_WIDTH-1:0]);
      end
      if (ser_wr && ser_idx == `CDT_IDX_IMASK) begin
        imask_q <= sin_next[`CDT_ST_WIDTH-1:0];
      end else if (ap_wr && ap_idx == `CDT_IDX_IMASK) begin
        imask_q <= (imask_q & ~ap_bmask[2:0]) | (pwdata[2:0] & ap_bmask[2:0]);
      end
      stat_q <= stat_d;
      irq <= |(stat_d & imask_q);

      // Trigger response
      state_q <= state_d;
      debug_irq <= fire & ctrl_q[`CDT_CTRL_RESP_IRQ];
      cpu_halt_req <= (state_d == ST_FIRED) & ~ctrl_q[`CDT_CTRL_RESP_IRQ];

      // Critical interrupts pass even while the debug handler runs
      if (!cpu_debug_isr) begin
        irq_level_fwd <= cpu_irq_level;
      end else if (ctrl_q[`CDT_CTRL_EMU] && cpu_irq_level >= crit_lvl &&
                   crit_lvl != 3'h0) begin
        irq_level_fwd <= cpu_irq_level;
      end else begin
        irq_level_fwd <= 3'h0;
      end

      // Trace: each edge of the trace clock marks a new core-cycle sample
      halt_indicator <= &pst_d;
      if (TRACE_EN != 0) begin
        processor_status_bus <= pst_d;
        trace_data_bus <= cpu_ddata;
        trace_clock_out <= ~trace_clock_out;
      end else begin
        processor_status_bus <= 4'h0;
        trace_data_bus <= 4'h0;
        trace_clock_out <= 1'b0;
      end
    end
  end

endmodule

// file: test/cdt_tool.sv
module cdt_tool (
  output logic      debug_serial_clock,
  output logic      debug_serial_in,
  input  wire logic debug_serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
  end
  // Clock rests low between frames; data idles inverted so a stale bit is never reused
  // Start off the core clock edge so no pin change races its sampling.
  // The reply's first bit already stands after the fall that closes the read frame.
  task automatic frame(input logic [39:0] f, output logic [31:0] rep);
    #2;
    for (int i = 39; i >= 0; i--) begin
      debug_serial_in = f[i];
      #62.5 debug_serial_clock = 1'b1;
      if (i >= 8) rep[i - 8] = debug_serial_out;
      #62.5 debug_serial_clock = 1'b0;
    end
    debug_serial_in = ~debug_serial_in;
  endtask
endmodule

// file: test/cdt_top_assertions.sv
module cdt_top_assertions #(
  parameter TRACE_EN = 1
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  cpu_status,
  input wire logic [3:0]  cpu_ddata,
  input wire logic        cpu_halted,
  input wire logic        cpu_debug_isr,
  input wire logic [2:0]  cpu_irq_level,
  input wire logic        cpu_halt_req,
  input wire logic        debug_irq,
  input wire logic [2:0]  irq_level_fwd,
  input wire logic [3:0]  processor_status_bus,
  input wire logic [3:0]  trace_data_bus,
  input wire logic        trace_clock_out,
  input wire logic        halt_indicator
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wait;
    psel && penable && !pready && ce;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence
  property p_ready;
    s_wait |=> s_pulse;
  endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_refuse;
    psel && penable && pready && (paddr > 12'h02c || (paddr <= 12'h020 && !pprot[0]))
      |-> pslverr && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access not refused");
  property p_halt;
    halt_indicator == &processor_status_bus;
  endproperty
  a_halt: assert property (p_halt) else $error("halt indicator wrong");
  // Guarded on ce and reset one cycle back, since those freeze or clear the trace flops
  property p_status;
    TRACE_EN && $past(ce) && !$past(srst)
      |-> processor_status_bus == ($past(cpu_halted) ? 4'hf : $past(cpu_status));
  endproperty
  a_status: assert property (p_status) else $error("status bus wrong");
  property p_ddata;
    TRACE_EN && $past(ce) && !$past(srst) |-> trace_data_bus == $past(cpu_ddata);
  endproperty
  a_ddata: assert property (p_ddata) else $error("data bus wrong");
  property p_tclk;
    TRACE_EN && $past(ce) && !$past(srst) |-> trace_clock_out != $past(trace_clock_out);
  endproperty
  a_tclk: assert property (p_tclk) else $error("trace clock stuck");
  property p_dirq;
    debug_irq |=> !debug_irq;
  endproperty
  a_dirq: assert property (p_dirq) else $error("debug irq too long");
  property p_excl;
    !(debug_irq && cpu_halt_req);
  endproperty
  a_excl: assert property (p_excl) else $error("both responses");
  property p_fwd;
    !$past(cpu_debug_isr) && $past(ce) && !$past(srst) |-> irq_level_fwd == $past(cpu_irq_level);
  endproperty
  a_fwd: assert property (p_fwd) else $error("level not passed");
endmodule

bind cdt_top cdt_top_assertions #(.TRACE_EN(TRACE_EN)) i_cdt_top_assertions (.*);

// file: test/core_debug_trigger_trace_bench.sv
`include "cdt_defines.vh"
module core_debug_trigger_trace_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  pprot = 3'h1;
  logic        cpu_addr_valid = 1'b0;
  logic        cpu_data_valid = 1'b0;
  logic        cpu_pc_valid = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic [31:0] cpu_data = 32'h0;
  logic [31:0] cpu_pc = 32'h0;
  logic [3:0]  cpu_status = 4'h0;
  logic [3:0]  cpu_ddata = 4'h0;
  logic        cpu_halted = 1'b0;
  logic        cpu_debug_isr = 1'b0;
  logic [2:0]  cpu_irq_level = 3'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, debug_serial_in, debug_serial_clock, debug_serial_out;
  wire         cpu_halt_req, debug_irq, trace_clock_out, halt_indicator, irq;
  wire  [2:0]  irq_level_fwd;
  wire  [3:0]  processor_status_bus, trace_data_bus;
  logic [31:0] rd, s, a, p, v[9];
  logic        err, h;
  logic [3:0]  st, dd;
  int          n_errors = 0, n_tests = 0, cyc = 0;

  cdt_top #(.TRACE_EN(1)) i_cdt_top (.*);
  cdt_tool i_cdt_tool (.*);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  function automatic logic [3:0] pst_exp(input logic hl, input logic [3:0] sc);
    return hl ? `CDT_PST_HALTED : sc;
  endfunction
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] ad, input logic [31:0] e, input logic ee);
    apb(1'b0, ad, 32'h0);
    chk(rd, e);
    chk({31'h0, err}, {31'h0, ee});
  endtask
  // Valids {pc, data, addr} for one cycle; returns just after the sampling edge
  task automatic drive(input logic [2:0] vl);
    @(posedge clk);
    {cpu_pc_valid, cpu_data_valid, cpu_addr_valid} <= vl;
    @(posedge clk);
    {cpu_pc_valid, cpu_data_valid, cpu_addr_valid} <= 3'h0;
    #1;
  endtask

  initial begin
    void'($urandom(47));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) rdchk(12'(i * 4), 32'h0, 1'b0);
    for (int i = 0; i < 9; i++) begin
      v[i] = $urandom;
      apb(1'b1, 12'(i * 4), v[i]);
    end
    for (int i = 0; i < 9; i++) rdchk(12'(i * 4), v[i], 1'b0);
    pprot <= 3'h0;
    rdchk(12'h008, 32'h0, 1'b1);
    apb(1'b1, 12'h008, 32'h1234_5678);
    pprot <= 3'h1;
    rdchk(12'h008, v[2], 1'b0);
    rdchk(12'h030, 32'h0, 1'b1);
    s = $urandom;
    i_cdt_tool.frame({8'h82, s}, rd);
    rdchk(12'h008, s, 1'b0);
    i_cdt_tool.frame({8'h02, 32'h0}, rd);
    i_cdt_tool.frame({8'h00, 32'h0}, a);
    chk(a, s);
    rdchk(`CDT_OFF_STAT, 32'h4, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `CDT_OFF_IMASK, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `CDT_OFF_STAT, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    a = $urandom;
    apb(1'b1, 12'h000, a);
    apb(1'b1, 12'h004, 32'h0000_00ff);
    apb(1'b1, `CDT_OFF_CTRL, 32'h0000_0005);
    cpu_addr <= a ^ 32'h0000_0100;
    drive(3'b001);
    chk({31'h0, cpu_halt_req}, 32'h0);
    cpu_addr <= a ^ 32'h0000_005a;
    drive(3'b001);
    chk({31'h0, cpu_halt_req}, 32'h1);
    apb(1'b1, `CDT_OFF_IMASK, 32'h2);
    apb(1'b1, `CDT_OFF_STAT, 32'h2);
    apb(1'b1, `CDT_OFF_CTRL, 32'h0000_0105);
    chk({31'h0, irq}, 32'h0);
    drive(3'b001);
    chk({31'h0, debug_irq}, 32'h1);
    chk({31'h0, cpu_halt_req}, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    p = $urandom;
    apb(1'b1, 12'h010, p);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, `CDT_OFF_CTRL, 32'h0000_0053);
    cpu_data <= s;
    cpu_pc <= p;
    drive(3'b010);
    chk({31'h0, cpu_halt_req}, 32'h0);
    drive(3'b100);
    chk({31'h0, cpu_halt_req}, 32'h0);
    drive(3'b010);
    chk({31'h0, cpu_halt_req}, 32'h1);
    pstrb <= 4'h3;
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    pstrb <= 4'hf;
    rdchk(12'h00c, 32'h0000_ffff, 1'b0);
    apb(1'b1, `CDT_OFF_CTRL, 32'h0000_1200);
    cpu_debug_isr <= 1'b1;
    for (int l = 0; l < 8; l++) begin
      cpu_irq_level <= 3'(l);
      repeat (2) @(posedge clk);
      chk(32'(irq_level_fwd), (l >= 4) ? 32'(l) : 32'h0);
    end
    cpu_debug_isr <= 1'b0;
    repeat (100) begin
      {h, st, dd} = 9'($urandom);
      cpu_halted <= h;
      cpu_status <= st;
      cpu_ddata <= dd;
      cpu_irq_level <= 3'($urandom);
      repeat (2) @(posedge clk);
      chk(32'(processor_status_bus), 32'(pst_exp(h, st)));
      chk(32'(trace_data_bus), 32'(dd));
      chk({31'h0, halt_indicator}, {31'h0, &pst_exp(h, st)});
    end
    // Clock enable low must freeze the processor status bus against changing halt and status inputs
    ce <= 1'b0;
    cpu_halted <= ~h;
    cpu_status <= ~st;
    repeat (3) @(posedge clk);
    chk(32'(processor_status_bus), 32'(pst_exp(h, st)));
    ce <= 1'b1;
    srst <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(processor_status_bus), 32'h0);
    srst <= 1'b0;
    rdchk(`CDT_OFF_CTRL, 32'h0, 1'b0);
    complete_run();
  end
endmodule
